// ---- logic/lcs_defines.svh ----
// timing counts, register offsets and reset values for the charge sequencer
// assumes a 25 MHz core clock; included by bare name wherever needed
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH

// clock and derived counts
`define LCS_CLK_PERIOD_NS      40
`define LCS_TICK_NS            1000000
`define LCS_TICK_CYCLES        (`LCS_TICK_NS / `LCS_CLK_PERIOD_NS)
`define LCS_VCC_FILT_NS        10000
`define LCS_VCC_FILT_CYCLES    ((`LCS_VCC_FILT_NS + `LCS_CLK_PERIOD_NS - 1) / `LCS_CLK_PERIOD_NS)
`define LCS_BLINK_TICKS        32'h0000_01F4

// register word indices (byte address = 4 * index)
`define LCS_REG_CTRL           4'h0
`define LCS_REG_TIMER_LIMIT    4'h1
`define LCS_REG_STATUS         4'h2
`define LCS_REG_TIMER_COUNT    4'h3

// field positions and reset values
`define LCS_CTRL_FORCE_OFF_BIT 0
`define LCS_TIMER_LIMIT_RST    32'h0089_5440

`endif

// ---- logic/lcs_pkg.sv ----
// types shared by the charge sequencer files
// assumes lcs_defines.svh carries all numeric constants
package lcs_pkg;

	// charge phase, one-hot
	typedef enum logic [8:0] {
		LCS_ST_OFF     = 9'h001,
		LCS_ST_PRE     = 9'h002,
		LCS_ST_CC      = 9'h004,
		LCS_ST_CV      = 9'h008,
		LCS_ST_FLOAT   = 9'h010,
		LCS_ST_MONITOR = 9'h020,
		LCS_ST_FAULT   = 9'h040,
		LCS_ST_LDO     = 9'h080,
		LCS_ST_RSVD    = 9'h100
	} lcs_state_e;

endpackage : lcs_pkg

// ---- logic/lcs_sync.sv ----
// two-flop synchroniser for a group of comparator flags
// assumes each bit is an independent level; no word coherence is kept
module lcs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// first stage feeds only the second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule : lcs_sync

// ---- logic/lcs_charge_seq.sv ----
// charge phase sequencer for a single-cell charger with Avalon-MM registers
// assumes comparator flags from the analog front end, 25 MHz core_clk
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`include "lcs_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Operation
// [R1] enable input low disables the device and keeps output off
// [R2] level inside hot/cold window means enabled with safe temperature
// [R3] level above 95 percent of supply drives battery absent high
// [R4] timer-select grounded disables charge timer and all timer limits
// [R5] timer-select at supply selects LDO mode instead of charging
// [R6] supply good is glitch filtered; charging starts only once filtered good
// [R7] charge start drives status output low, charging indicator on
// [R8] battery below 2.8 V selects pre-charge current
// [R9] battery above 2.8 V and below final selects constant current
// [R10] battery reaching 4.2 V switches to constant voltage
// [R11] current below termination drives status output high, complete
// [R12] timer on: float in constant voltage until timer expiry, then monitor
// [R13] timer off: output turns off as soon as termination is reached
// [R14] LDO mode never turns output off on termination
// [R15] monitor holds output off until battery drops 100 mV, then recharges
// [R16] timer on and pre-charge beyond quarter charge time gives fault, off
// [R17] pre-charge fault clears on enable or supply toggle, or above 2.8 V
// [R18] thermistor out of window suspends: off, timer frozen, fault shown
// [R19] recharge from monitor clears the charge timer first
// [R20] LDO output on only while enable level above 90 percent
// [R21] analog comparator flags are synchronised before use
// [R22] timer counts on-time to a programmable limit; fault at one quarter
module lcs_charge_seq #(
	parameter logic [31:0] TICK_CYCLES = `LCS_TICK_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        vcc_good_in,
	input  wire logic        ent_low_in,
	input  wire logic        ent_hot_in,
	input  wire logic        ent_cold_in,
	input  wire logic        ent_ldo_in,
	input  wire logic        ent_battery_absent_out_in,
	input  wire logic        vbat_above_pre_in,
	input  wire logic        vbat_at_cv_in,
	input  wire logic        vbat_below_rech_in,
	input  wire logic        iout_below_term_in,
	input  wire logic        rtime_gnd_in,
	input  wire logic        rtime_vcc_in,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             charger_output,
	output logic             pre_sel_out,
	output logic             cc_sel_out,
	output logic             cv_sel_out,
	output logic             charge_status_out,
	output logic             charge_status_oe_n,
	output logic             battery_absent_out
);

	////////////////////////////////////////////////////////////////////////
	// input synchronisation
	logic [11:0] raw_flags;
	logic [11:0] sync_flags;
	logic        vcc_good_s;
	logic        ent_low_s;
	logic        ent_hot_s;
	logic        ent_cold_s;
	logic        ent_ldo_s;
	logic        ent_battery_absent_out_s;
	logic        vbat_above_s;
	logic        vbat_cv_s;
	logic        vbat_rech_s;
	logic        iout_term_s;
	logic        rtime_gnd_s;
	logic        rtime_vcc_s;

	assign raw_flags = {vcc_good_in, ent_low_in, ent_hot_in, ent_cold_in, ent_ldo_in, ent_battery_absent_out_in,
		vbat_above_pre_in, vbat_at_cv_in, vbat_below_rech_in, iout_below_term_in, rtime_gnd_in, rtime_vcc_in};

	// all comparator levels cross into core_clk here
	lcs_sync #(
		.WIDTH (12)
	) u_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.d        (raw_flags), // R21
		.q        (sync_flags)
	);

	assign {vcc_good_s, ent_low_s, ent_hot_s, ent_cold_s, ent_ldo_s, ent_battery_absent_out_s,
		vbat_above_s, vbat_cv_s, vbat_rech_s, iout_term_s, rtime_gnd_s, rtime_vcc_s} = sync_flags;

	////////////////////////////////////////////////////////////////////////
	// supply glitch filter
	logic       vcc_filt_ff;
	logic       nxt_vcc_filt;
	logic [7:0] vcc_cnt_ff;
	logic [7:0] nxt_vcc_cnt;

	// new level must persist for the filter time
	always_comb begin
		nxt_vcc_filt = vcc_filt_ff;
		nxt_vcc_cnt  = 8'h00;
		if (vcc_good_s != vcc_filt_ff) begin
			if (vcc_cnt_ff == 8'(`LCS_VCC_FILT_CYCLES - 1)) begin
				nxt_vcc_filt = vcc_good_s; // R6
			end else begin
				nxt_vcc_cnt = vcc_cnt_ff + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vcc_filt_ff <= 1'b0;
			vcc_cnt_ff  <= 8'h00;
		end else begin
			vcc_filt_ff <= nxt_vcc_filt;
			vcc_cnt_ff  <= nxt_vcc_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// millisecond tick and fault blink
	logic [31:0] tick_cnt_ff;
	logic [31:0] nxt_tick_cnt;
	logic [31:0] blink_cnt_ff;
	logic [31:0] nxt_blink_cnt;
	logic        blink_ff;
	logic        nxt_blink;
	logic        tick;

	assign tick = (tick_cnt_ff == TICK_CYCLES - 32'h0000_0001);

	// free-running prescaler, blink toggles every blink period
	always_comb begin
		nxt_tick_cnt  = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
		nxt_blink_cnt = blink_cnt_ff;
		nxt_blink     = blink_ff;
		if (tick) begin
			if (blink_cnt_ff == `LCS_BLINK_TICKS - 32'h0000_0001) begin
				nxt_blink_cnt = 32'h0000_0000;
				nxt_blink     = !blink_ff;
			end else begin
				nxt_blink_cnt = blink_cnt_ff + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tick_cnt_ff  <= 32'h0000_0000;
			blink_cnt_ff <= 32'h0000_0000;
			blink_ff     <= 1'b0;
		end else begin
			tick_cnt_ff  <= nxt_tick_cnt;
			blink_cnt_ff <= nxt_blink_cnt;
			blink_ff     <= nxt_blink;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, registered read data
	lcs_pkg::lcs_state_e state_ff;
	lcs_pkg::lcs_state_e nxt_state;
	logic        ack_ff;
	logic        nxt_ack;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] limit_ff;
	logic [31:0] nxt_limit;
	logic        force_off_ff;
	logic        nxt_force_off;
	logic [31:0] timer_ff;
	logic [31:0] nxt_timer;
	logic        done_ff;
	logic        nxt_done;
	logic        bus_req;
	logic        en_ok;
	logic        ldo_mode;
	logic        timer_en;
	logic        ntc_fault;
	logic        expired;

	assign bus_req         = avs_read || avs_write;
	assign avs_waitrequest = bus_req && !ack_ff;
	assign avs_readdata    = rdata_ff;

	// decode on the first cycle, write lands on the released edge
	always_comb begin
		nxt_ack       = bus_req && !ack_ff;
		nxt_rdata     = rdata_ff;
		nxt_limit     = limit_ff;
		nxt_force_off = force_off_ff;
		if (avs_read && !ack_ff) begin
			case (avs_address)
				`LCS_REG_CTRL:        nxt_rdata = {31'h0000_0000, force_off_ff};
				`LCS_REG_TIMER_LIMIT: nxt_rdata = limit_ff;
				`LCS_REG_STATUS:      nxt_rdata = {10'h000, battery_absent_out, vcc_filt_ff, done_ff,
					timer_en, ldo_mode, ntc_fault, 7'h00, state_ff};
				`LCS_REG_TIMER_COUNT: nxt_rdata = timer_ff;
				default:              nxt_rdata = 32'h0000_0000;
			endcase
		end
		if (avs_write && ack_ff) begin
			if (avs_address == `LCS_REG_CTRL && avs_byteenable[0]) begin
				nxt_force_off = avs_writedata[`LCS_CTRL_FORCE_OFF_BIT];
			end
			if (avs_address == `LCS_REG_TIMER_LIMIT) begin
				for (int i = 0; i < 4; i++) begin
					if (avs_byteenable[i]) begin
						nxt_limit[i*8 +: 8] = avs_writedata[i*8 +: 8]; // R22
					end
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_ff       <= 1'b0;
			rdata_ff     <= 32'h0000_0000;
			limit_ff     <= `LCS_TIMER_LIMIT_RST;
			force_off_ff <= 1'b0;
		end else begin
			ack_ff       <= nxt_ack;
			rdata_ff     <= nxt_rdata;
			limit_ff     <= nxt_limit;
			force_off_ff <= nxt_force_off;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// charge phase machine with timer and completion latch
	assign en_ok     = vcc_filt_ff && !ent_low_s && !force_off_ff; // R1 R6
	assign ldo_mode  = rtime_vcc_s; // R5
	assign timer_en  = !rtime_gnd_s && !rtime_vcc_s; // R4
	assign ntc_fault = !ldo_mode && (ent_hot_s || ent_cold_s); // R2 R18
	assign expired   = timer_en && (timer_ff >= limit_ff); // R12

	always_comb begin
		nxt_state = state_ff;
		nxt_timer = timer_ff;
		nxt_done  = done_ff;
		if (!en_ok) begin
			nxt_state = lcs_pkg::LCS_ST_OFF; // R1 R17
			nxt_timer = 32'h0000_0000;
			nxt_done  = 1'b0;
		end else if (ldo_mode) begin
			nxt_state = lcs_pkg::LCS_ST_LDO; // R5 R14
			if (state_ff == lcs_pkg::LCS_ST_LDO && ent_ldo_s && iout_term_s) begin
				nxt_done = 1'b1;
			end
		end else if (state_ff == lcs_pkg::LCS_ST_LDO) begin
			nxt_state = lcs_pkg::LCS_ST_OFF;
		end else if (!ntc_fault) begin
			// on-time only; frozen while the thermistor is out of window
			if (timer_en && tick && state_ff inside {lcs_pkg::LCS_ST_PRE, lcs_pkg::LCS_ST_CC,
				lcs_pkg::LCS_ST_CV, lcs_pkg::LCS_ST_FLOAT}) begin
				nxt_timer = timer_ff + 32'h0000_0001; // R22 R18
			end
			unique case (state_ff)
				lcs_pkg::LCS_ST_OFF: begin
					nxt_state = lcs_pkg::LCS_ST_PRE; // R6 R7
					nxt_timer = 32'h0000_0000;
					nxt_done  = 1'b0;
				end
				lcs_pkg::LCS_ST_PRE: begin
					if (vbat_above_s) begin
						nxt_state = lcs_pkg::LCS_ST_CC; // R9
					end else if (timer_en && timer_ff >= (limit_ff >> 2)) begin
						nxt_state = lcs_pkg::LCS_ST_FAULT; // R16 R22
					end
				end
				lcs_pkg::LCS_ST_CC: begin
					if (vbat_cv_s) begin
						nxt_state = lcs_pkg::LCS_ST_CV; // R10
					end else if (!vbat_above_s) begin
						nxt_state = lcs_pkg::LCS_ST_PRE; // R8
					end else if (expired) begin
						nxt_state = lcs_pkg::LCS_ST_MONITOR;
					end
				end
				lcs_pkg::LCS_ST_CV: begin
					if (iout_term_s) begin
						nxt_done  = 1'b1; // R11
						nxt_state = timer_en ? lcs_pkg::LCS_ST_FLOAT : lcs_pkg::LCS_ST_MONITOR; // R12 R13
					end else if (expired) begin
						nxt_state = lcs_pkg::LCS_ST_MONITOR;
					end
				end
				lcs_pkg::LCS_ST_FLOAT: begin
					if (expired || !timer_en) begin
						nxt_state = lcs_pkg::LCS_ST_MONITOR; // R12
					end
				end
				lcs_pkg::LCS_ST_MONITOR: begin
					if (vbat_rech_s) begin
						nxt_state = lcs_pkg::LCS_ST_PRE; // R15
						nxt_timer = 32'h0000_0000; // R19
						nxt_done  = 1'b0;
					end
				end
				lcs_pkg::LCS_ST_FAULT: begin
					if (vbat_above_s) begin
						nxt_state = lcs_pkg::LCS_ST_CC; // R17
					end
				end
				lcs_pkg::LCS_ST_LDO: begin
					nxt_state = lcs_pkg::LCS_ST_OFF;
				end
				default: begin
					nxt_state = lcs_pkg::LCS_ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= lcs_pkg::LCS_ST_OFF;
			timer_ff <= 32'h0000_0000;
			done_ff  <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			timer_ff <= nxt_timer;
			done_ff  <= nxt_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered pin drivers
	logic nxt_out_on;
	logic nxt_status;
	logic nxt_status_oe_n;
	logic nxt_battery_absent_out;
	logic charging;

	assign charging = state_ff inside {lcs_pkg::LCS_ST_PRE, lcs_pkg::LCS_ST_CC,
		lcs_pkg::LCS_ST_CV, lcs_pkg::LCS_ST_FLOAT};

	// output, regulation select and indicators from present phase
	always_comb begin
		nxt_out_on      = en_ok && ((charging && !ntc_fault) || // R18 R15
			(state_ff == lcs_pkg::LCS_ST_LDO && ent_ldo_s)); // R20 R14
		nxt_status_oe_n = !en_ok;
		nxt_status      = (ntc_fault || state_ff == lcs_pkg::LCS_ST_FAULT) ? blink_ff : done_ff; // R7 R11 R18
		nxt_battery_absent_out       = vcc_filt_ff && ent_battery_absent_out_s; // R3
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			charger_output     <= 1'b0;
			pre_sel_out        <= 1'b0;
			cc_sel_out         <= 1'b0;
			cv_sel_out         <= 1'b0;
			charge_status_out  <= 1'b0;
			charge_status_oe_n <= 1'b1;
			battery_absent_out <= 1'b0;
		end else begin
			charger_output     <= nxt_out_on;
			pre_sel_out        <= (state_ff == lcs_pkg::LCS_ST_PRE); // R8
			cc_sel_out         <= (state_ff == lcs_pkg::LCS_ST_CC); // R9
			cv_sel_out         <= state_ff inside {lcs_pkg::LCS_ST_CV, lcs_pkg::LCS_ST_FLOAT, lcs_pkg::LCS_ST_LDO}; // R10
			charge_status_out  <= nxt_status;
			charge_status_oe_n <= nxt_status_oe_n;
			battery_absent_out <= nxt_battery_absent_out;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	logic run_ok;
	assign run_ok = en_ok && !ldo_mode && !ntc_fault;

	sequence s_start;
		state_ff == lcs_pkg::LCS_ST_OFF && run_ok;
	endsequence

	sequence s_in_pre;
		state_ff == lcs_pkg::LCS_ST_PRE && !ntc_fault && en_ok;
	endsequence

	AST_DISABLE_OFF: assert property (!en_ok |=> state_ff == lcs_pkg::LCS_ST_OFF ##1 !charger_output) // R1
		else $error("output not off after disable");
	AST_BATTERY_ABSENT_OUT_HIGH: assert property (vcc_filt_ff && ent_battery_absent_out_s |=> battery_absent_out) // R3
		else $error("battery absent not raised");
	AST_NO_TIMER_NO_FAULT: assert property (state_ff == lcs_pkg::LCS_ST_PRE && !timer_en && run_ok
		|=> state_ff != lcs_pkg::LCS_ST_FAULT) // R4
		else $error("pre-charge fault with timer disabled");
	AST_LDO_SELECT: assert property (en_ok && ldo_mode |=> state_ff == lcs_pkg::LCS_ST_LDO) // R5
		else $error("LDO mode not selected");
	AST_START_STATUS_LOW: assert property (s_start ##1 s_in_pre |=> !charge_status_out && !charge_status_oe_n) // R7
		else $error("status not low at charge start");
	AST_PRE_TO_CC: assert property (state_ff == lcs_pkg::LCS_ST_PRE && vbat_above_s && run_ok
		|=> state_ff == lcs_pkg::LCS_ST_CC ##1 cc_sel_out) // R9
		else $error("no switch to constant current");
	AST_CC_TO_CV: assert property (state_ff == lcs_pkg::LCS_ST_CC && vbat_cv_s && run_ok
		|=> state_ff == lcs_pkg::LCS_ST_CV) // R10
		else $error("no switch to constant voltage");
	AST_TERM_NO_TIMER: assert property (state_ff == lcs_pkg::LCS_ST_CV && iout_term_s && !timer_en && run_ok
		|=> state_ff == lcs_pkg::LCS_ST_MONITOR && done_ff ##1 !charger_output) // R13 R11
		else $error("output not off at termination");
	AST_PRE_FAULT: assert property (state_ff == lcs_pkg::LCS_ST_PRE && timer_en && !vbat_above_s && run_ok
		&& timer_ff >= (limit_ff >> 2) |=> state_ff == lcs_pkg::LCS_ST_FAULT ##1 !charger_output) // R16
		else $error("pre-charge timeout not faulted");
	AST_NTC_FREEZE: assert property (ntc_fault && en_ok && state_ff != lcs_pkg::LCS_ST_LDO
		|=> $stable(timer_ff) && !charger_output) // R18
		else $error("thermistor suspend not honoured");
	AST_RECHARGE_CLEAR: assert property (state_ff == lcs_pkg::LCS_ST_MONITOR && vbat_rech_s && run_ok
		|=> state_ff == lcs_pkg::LCS_ST_PRE && timer_ff == 32'h0000_0000) // R19 R15
		else $error("recharge did not clear timer");
	AST_LDO_LEVEL: assert property (state_ff == lcs_pkg::LCS_ST_LDO && !ent_ldo_s |=> !charger_output) // R20
		else $error("LDO output on below level");

endmodule : lcs_charge_seq

// ---- verification/lcs_pack_model.sv ----
// battery pack and thermistor divider model: analog levels to comparator flags
// assumes the bench sets vbat_mv, iout_ma and ntc_pct (percent of supply) directly
module lcs_pack_model (
	output logic ent_low_in,
	output logic ent_hot_in,
	output logic ent_cold_in,
	output logic ent_ldo_in,
	output logic ent_battery_absent_out_in,
	output logic vbat_above_pre_in,
	output logic vbat_at_cv_in,
	output logic vbat_below_rech_in,
	output logic iout_below_term_in
);
	timeunit 1ns;
	timeprecision 1ns;
	parameter int LOW_PCT  = 10;
	parameter int TERM_MA  = 50;
	int vbat_mv = 2500;
	int iout_ma = 300;
	int ntc_pct = 50;

	// comparators always drive, so no released level exists here
	always_comb begin
		ent_low_in         = ntc_pct < LOW_PCT;
		ent_hot_in         = ntc_pct >= LOW_PCT && ntc_pct < 30;
		ent_cold_in        = ntc_pct > 75;
		ent_ldo_in         = ntc_pct > 90;
		ent_battery_absent_out_in       = ntc_pct > 95;
		vbat_above_pre_in  = vbat_mv > 2800;
		vbat_at_cv_in      = vbat_mv >= 4200;
		vbat_below_rech_in = vbat_mv < 4100;
		iout_below_term_in = iout_ma < TERM_MA;
	end
endmodule : lcs_pack_model

// ---- verification/liion_charge_sequencer_bench.sv ----
// self-checking bench for the charge sequencer
// assumes the pack model drives the battery and thermistor comparator flags; supply good and timer-select flags come from the bench
`include "lcs_defines.svh"
module liion_charge_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 0;
	logic        resetn = 0;
	logic        vcc_good_in = 0;
	logic        rtime_gnd_in = 0;
	logic        rtime_vcc_in = 0;
	logic [3:0]  avs_address = 0;
	logic        avs_read = 0;
	logic        avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest, charger_output, pre_sel_out, cc_sel_out, cv_sel_out;
	logic        charge_status_out, charge_status_oe_n, battery_absent_out;
	logic        ent_low_in, ent_hot_in, ent_cold_in, ent_ldo_in, ent_battery_absent_out_in;
	logic        vbat_above_pre_in, vbat_at_cv_in, vbat_below_rech_in, iout_below_term_in;
	logic [3:0]  outs;
	logic [31:0] seed = 32'h0000_000A;
	int          failures = 0;
	int          n_checks = 0;
	int          cyc = 0;

	// pass device and regulation selects seen together
	assign outs = {charger_output, pre_sel_out, cc_sel_out, cv_sel_out};

	lcs_charge_seq #(.TICK_CYCLES(32'h0000_0004)) u_dut (.core_clk, .resetn, .vcc_good_in, .ent_low_in,
		.ent_hot_in, .ent_cold_in, .ent_ldo_in, .ent_battery_absent_out_in, .vbat_above_pre_in, .vbat_at_cv_in,
		.vbat_below_rech_in, .iout_below_term_in, .rtime_gnd_in, .rtime_vcc_in, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .charger_output,
		.pre_sel_out, .cc_sel_out, .cv_sel_out, .charge_status_out, .charge_status_oe_n, .battery_absent_out);

	lcs_pack_model u_pack (.ent_low_in, .ent_hot_in, .ent_cold_in, .ent_ldo_in, .ent_battery_absent_out_in,
		.vbat_above_pre_in, .vbat_at_cv_in, .vbat_below_rech_in, .iout_below_term_in);

	// 25 MHz clock
	initial begin
		forever #20 core_clk = ~core_clk;
	end

	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	// expected pass device and selects for a phase
	function automatic logic [3:0] expo(input logic [8:0] ph);
		case (ph)
			lcs_pkg::LCS_ST_PRE: return 4'hC;
			lcs_pkg::LCS_ST_CC: return 4'hA;
			lcs_pkg::LCS_ST_CV, lcs_pkg::LCS_ST_FLOAT, lcs_pkg::LCS_ST_LDO: return 4'h9;
			default: return 4'h0;
		endcase
	endfunction : expo

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// one Avalon-MM transfer, held until waitrequest is low at a rising edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		logic ok;
		@(posedge core_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= d;
		// waitrequest and read data are taken at the rising edge itself
		do begin
			@(posedge core_clk);
			ok = !avs_waitrequest;
			q = avs_readdata;
		end while (!ok);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0000_0000, q);
	endtask : rd

	task automatic lv(input int v, input int i, input int n);
		u_pack.vbat_mv <= v;
		u_pack.iout_ma <= i;
		u_pack.ntc_pct <= n;
	endtask : lv

	// poll the phase field, then compare outputs with the phase model
	task automatic wait_ph(input logic [8:0] ph);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			rd(4'h2, q);
			n++;
		end while (q[8:0] !== ph && n < 300);
		check(q[8:0], ph);
		repeat (3) @(posedge core_clk);
		check(outs, expo(ph));
		if (ph == lcs_pkg::LCS_ST_PRE || ph == lcs_pkg::LCS_ST_CC || ph == lcs_pkg::LCS_ST_CV)
			check(charge_status_out, 1'b0);
		else if (ph == lcs_pkg::LCS_ST_FLOAT || ph == lcs_pkg::LCS_ST_MONITOR)
			check(charge_status_out, 1'b1);
	endtask : wait_ph

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		logic [31:0] q, t;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		rd(4'h0, q);
		check(q, 32'h0000_0000);
		rd(4'h1, q);
		check(q, `LCS_TIMER_LIMIT_RST);
		rd(4'h9, q);
		check(q, 32'h0000_0000);
		wr(4'h2, 32'hFFFF_FFFF);
		rd(4'h2, q);
		check(q[8:0], lcs_pkg::LCS_ST_OFF);
		t = rnd();
		wr(4'h1, t);
		rd(4'h1, q);
		check(q, t);
		avs_byteenable <= 4'h2;
		wr(4'h1, 32'hFFFF_FFFF);
		avs_byteenable <= 4'hF;
		rd(4'h1, q);
		check(q, {t[31:16], 8'hFF, t[7:0]});
		wr(4'h1, 32'h0000_0028);
		$display("registers done");
		vcc_good_in <= 1'b1;
		repeat (100) @(posedge core_clk);
		vcc_good_in <= 1'b0;
		repeat (20) @(posedge core_clk);
		vcc_good_in <= 1'b1;
		repeat (150) @(posedge core_clk);
		rd(4'h2, q);
		check(q[8:0], lcs_pkg::LCS_ST_OFF);
		wait_ph(lcs_pkg::LCS_ST_PRE);
		check(charge_status_oe_n, 1'b0);
		lv(2900 + int'(rnd() % 1200), 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CC);
		lv(4200, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CV);
		lv(4200, 20, 50);
		wait_ph(lcs_pkg::LCS_ST_FLOAT);
		wait_ph(lcs_pkg::LCS_ST_MONITOR);
		lv(4050, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CC);
		rd(4'h3, q);
		check(q < 32'd10, 1'b1);
		$display("charge cycle done");
		lv(4050, 300, 20);
		repeat (10) @(posedge core_clk);
		check(charger_output, 1'b0);
		rd(4'h2, q);
		check(q[16], 1'b1);
		rd(4'h3, t);
		repeat (40) @(posedge core_clk);
		rd(4'h3, q);
		check(q, t);
		lv(4050, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CC);
		$display("thermistor suspend done");
		rtime_gnd_in <= 1'b1;
		lv(4200, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CV);
		lv(4200, 20, 50);
		wait_ph(lcs_pkg::LCS_ST_MONITOR);
		rd(4'h2, q);
		check(q[18], 1'b0);
		lv(2500, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_PRE);
		repeat (80) @(posedge core_clk);
		rd(4'h2, q);
		check(q[8:0], lcs_pkg::LCS_ST_PRE);
		$display("timer off done");
		rtime_gnd_in <= 1'b0;
		lv(2500, 300, 5);
		wait_ph(lcs_pkg::LCS_ST_OFF);
		check(charge_status_oe_n, 1'b1);
		lv(2500, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_PRE);
		wait_ph(lcs_pkg::LCS_ST_FAULT);
		lv(3000, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CC);
		$display("precharge fault done");
		rtime_vcc_in <= 1'b1;
		lv(3000, 300, 92);
		wait_ph(lcs_pkg::LCS_ST_LDO);
		rd(4'h2, q);
		check(q[17], 1'b1);
		lv(3000, 20, 92);
		repeat (100) @(posedge core_clk);
		check(charger_output, 1'b1);
		lv(3000, 20, 97);
		repeat (10) @(posedge core_clk);
		check({battery_absent_out, charger_output}, 2'h3);
		lv(3000, 20, 85);
		repeat (10) @(posedge core_clk);
		check({battery_absent_out, charger_output}, 2'h0);
		$display("ldo mode done");
		rtime_vcc_in <= 1'b0;
		lv(3000, 300, 50);
		wait_ph(lcs_pkg::LCS_ST_CC);
		wr(4'h0, 32'h0000_0001);
		wait_ph(lcs_pkg::LCS_ST_OFF);
		wr(4'h0, 32'h0000_0000);
		$display("force off done");
		summarize();
	end
endmodule : liion_charge_sequencer_bench
